// >>> hw/rtst_pkg.sv
// Constants, register map and field layout of the real-time counter block
package rtst_pkg;
    // Counter geometry
    localparam int RTC_W = 67;
    localparam int FRAC_W = 16;
    localparam int INC_W = 32;
    localparam int SYST_W = 34;
    localparam int NCH = 5;
    // Bit positions of the views inside the fractional-microsecond counter, and of the 1 us slice inside the system timer
    localparam int T8U_LSB = FRAC_W + 3;
    localparam int T524M_LSB = FRAC_W + 19;
    localparam int SYST_LSB = FRAC_W - 2;
    localparam int SYST_1US_LSB = 2;
    // One 32.768 kHz period in microseconds with 16 fraction bits
    localparam logic [INC_W-1:0] INC_RESET = 32'h001E_8480;
    // Past window of late compares: 2**22 ticks of the selected slice
    localparam logic [31:0] PAST_WIN = 32'h0040_0000;
    // Timing of the system timer's quarter-microsecond step
    localparam int CLK_PERIOD_PS = 10000;
    localparam int SYST_RES_PS = 250000;
    localparam int SYST_DIV = (SYST_RES_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DIV_W = 5;
    // Register byte offsets
    localparam logic [11:0] REG_INC = 12'h000;
    localparam logic [11:0] REG_T8U = 12'h004;
    localparam logic [11:0] REG_T524M = 12'h008;
    localparam logic [11:0] REG_RTC_CMP = 12'h00C;
    localparam logic [11:0] REG_RTC_CAP = 12'h010;
    localparam logic [11:0] REG_SYST = 12'h014;
    localparam logic [11:0] REG_STATUS = 12'h018;
    localparam logic [11:0] REG_MASK = 12'h01C;
    localparam logic [11:0] REG_CH_BASE = 12'h020;
    localparam int CH_STRIDE_SH = 3;
    localparam logic [11:0] CH_CFG_OFS = 12'h000;
    localparam logic [11:0] CH_VAL_OFS = 12'h004;
    // Channel configuration fields
    localparam int CFG_RES_1US = 0;
    localparam int CFG_CMP = 1;
    localparam int CFG_W = 2;
    // Status and mask layout
    localparam int ST_RTC_CMP = 0;
    localparam int ST_RTC_CAP = 1;
    localparam int ST_CH = 2;
    localparam int ST_W = ST_CH + NCH;
    // Channel allocation
    localparam int CH_SYSTEM = 0;
    localparam int CH_RADIO_FIRST = 1;
    localparam int CH_RADIO_LAST = 3;
    localparam int CH_USER = 4;
    localparam logic [31:0] REG_ZERO = 32'h0000_0000;
endpackage

// >>> hw/rtst_timebase.sv
// Real-time counter and five-channel system timer with APB registers
// Notes on behaviour
// - 67-bit time accumulator, two channels, advanced only by low-frequency ticks.
// - Counter runs in standby and active; cleared by reset or shutdown.
// - Each low-frequency tick adds the programmed period increment.
// - Period increment is microseconds with sixteen fraction bits.
// - Read-only 32-bit view with 8 us per bit.
// - Read-only 32-bit view with 524 ms per bit.
// - One compare and one capture channel; compare match raises wake.
// - System timer is kept aligned to the real-time counter by hardware.
// - System timer is 34 bits, wraps, serves five channels.
// - Each channel picks a 1 us or 250 ns 32-bit slice.
// - Channels capture or single-shot compare; one event until re-armed.
// - Channel 0 system, channels 1 to 3 radio, channel 4 user.
// - Compare value in the recent past fires at once.
// - Low-frequency ticks keep counting in standby; they are sampled on pclk, so the fast clock must keep running.
`timescale 1ns/100ps
module rtst_timebase
    import rtst_pkg::*;
(
    input wire logic pclk, // Bus and system clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, high for write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic low_freq_clock, // Low-frequency clock level
    input wire logic shutdown, // Shutdown entry clears the time base
    input wire logic rtc_cap_trig, // Capture trigger of the real-time counter
    input wire logic [NCH-1:0] ch_cap_trig, // Capture triggers per channel
    output logic [NCH-1:0] ch_event, // Channel event pulses
    output logic rtc_wake, // Standby wake request
    output logic irq // Level interrupt
);

    // Slice of the system timer at the channel's resolution
    function automatic logic [31:0] pick_slice(input logic [SYST_W-1:0] t,
                                               input logic res_1us);
        pick_slice = res_1us ? t[SYST_1US_LSB +: 32] : t[31:0];
    endfunction

    // True when a compare value has been reached or lies in the past window
    function automatic logic reached(input logic [31:0] now,
                                     input logic [31:0] target,
                                     input logic [31:0] window);
        logic [31:0] diff;
        diff = now - target;
        reached = diff < window;
    endfunction

    logic lf_q;
    logic lf_tick;
    logic [RTC_W-1:0] rtc_q;
    logic [RTC_W-1:0] rtc_sum;
    logic [INC_W-1:0] inc_q;
    logic [DIV_W-1:0] div_q;
    logic syst_tick;
    logic [SYST_W-1:0] syst_q;
    logic [31:0] t8u;
    logic [31:0] t524m;
    logic [31:0] rtc_cmp_q;
    logic rtc_armed_q;
    logic rtc_fire;
    logic [31:0] rtc_cap_q;
    logic [ST_W-1:0] sts_q;
    logic [ST_W-1:0] mask_q;
    logic [ST_W-1:0] sts_set;
    logic [ST_W-1:0] sts_clr;
    logic [31:0] prdata_q;
    logic setup;
    logic wr_en;
    logic rd_done;
    logic addr_ok;
    logic [11:0] ch_ofs;
    logic [8:0] ch_idx;
    logic ch_hit;
    logic [CFG_W-1:0] ch_cfg [NCH];
    logic [31:0] ch_val [NCH];
    logic [NCH-1:0] ch_armed;
    logic [NCH-1:0] ch_ev;
    logic [31:0] rd_mux;

    // Edge of the low-frequency clock gives one tick per period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_q <= 1'b0;
        end else begin
            lf_q <= low_freq_clock;
        end
    end
    assign lf_tick = low_freq_clock & ~lf_q;

    // Accumulator in microseconds with sixteen fraction bits
    assign rtc_sum = rtc_q + {{(RTC_W-INC_W){1'b0}}, inc_q};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_q <= '0;
        end else if (shutdown) begin
            rtc_q <= '0;
        end else if (lf_tick) begin
            rtc_q <= rtc_sum;
        end
    end

    // Views: 8 us and 524 ms per bit; the wide one ends at bit 66
    assign t8u = rtc_q[T8U_LSB +: 32];
    assign t524m = rtc_q[T524M_LSB +: 32];

    // Quarter-microsecond step enable from the bus clock
    assign syst_tick = (div_q == DIV_W'(SYST_DIV - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (syst_tick || lf_tick || shutdown) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // System timer; reloaded from the accumulator on every tick so the
    // two never drift, at the cost of a small step at each realignment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            syst_q <= '0;
        end else if (shutdown) begin
            syst_q <= '0;
        end else if (lf_tick) begin
            syst_q <= rtc_sum[SYST_LSB +: SYST_W];
        end else if (syst_tick) begin
            syst_q <= syst_q + 1'b1;
        end
    end

    // Bus phases and address decode
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign rd_done = psel & penable & ~pwrite;
    assign ch_ofs = paddr - REG_CH_BASE;
    assign ch_idx = ch_ofs[11:CH_STRIDE_SH];
    assign ch_hit = (paddr >= REG_CH_BASE) && (ch_idx < 9'(NCH))
                    && (paddr[1:0] == 2'b00);
    assign addr_ok = ch_hit || (paddr <= REG_MASK && paddr[1:0] == 2'b00);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // Period increment, reprogrammable at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inc_q <= INC_RESET;
        end else if (wr_en && paddr == REG_INC) begin
            inc_q <= pwdata;
        end
    end

    // Real-time compare: armed by a write, fires once when reached
    assign rtc_fire = rtc_armed_q
                      && reached(t8u, rtc_cmp_q, 32'h8000_0000);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_cmp_q <= REG_ZERO;
            rtc_armed_q <= 1'b0;
        end else if (wr_en && paddr == REG_RTC_CMP) begin
            rtc_cmp_q <= pwdata;
            rtc_armed_q <= 1'b1;
        end else if (rtc_fire) begin
            rtc_armed_q <= 1'b0;
        end
    end

    // Real-time capture of the 8 us view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_cap_q <= REG_ZERO;
        end else if (rtc_cap_trig) begin
            rtc_cap_q <= t8u;
        end
    end

    // System timer channels; allocation is by software convention only
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            logic [31:0] now;
            logic wr_cfg;
            logic wr_val;
            logic fire;
            logic cap;
            assign now = pick_slice(syst_q, ch_cfg[gi][CFG_RES_1US]);
            assign wr_cfg = wr_en && ch_hit && ch_idx == 9'(gi)
                            && ch_ofs[2:0] == CH_CFG_OFS[2:0];
            assign wr_val = wr_en && ch_hit && ch_idx == 9'(gi)
                            && ch_ofs[2:0] == CH_VAL_OFS[2:0];
            // Late values fire at once through the past window
            assign fire = ch_armed[gi] && ch_cfg[gi][CFG_CMP]
                          && reached(now, ch_val[gi], PAST_WIN);
            assign cap = ~ch_cfg[gi][CFG_CMP] & ch_cap_trig[gi];

            // Configuration; a change disarms to avoid a stray event
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ch_cfg[gi] <= '0;
                end else if (wr_cfg) begin
                    ch_cfg[gi] <= pwdata[CFG_W-1:0];
                end
            end

            // Compare value or captured slice
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ch_val[gi] <= REG_ZERO;
                end else if (wr_val) begin
                    ch_val[gi] <= pwdata;
                end else if (cap) begin
                    ch_val[gi] <= now;
                end
            end

            // Single shot: a fire disarms until the value is written again
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ch_armed[gi] <= 1'b0;
                end else if (wr_val) begin
                    ch_armed[gi] <= ch_cfg[gi][CFG_CMP];
                end else if (wr_cfg || fire) begin
                    ch_armed[gi] <= 1'b0;
                end
            end

            // Event pulse, one cycle
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ch_ev[gi] <= 1'b0;
                end else begin
                    ch_ev[gi] <= fire | cap;
                end
            end
        end
    endgenerate
    assign ch_event = ch_ev;

    // Sticky status; a read clears only what it returned, so a new
    // event in the same cycle survives
    assign sts_set = {ch_ev, rtc_cap_trig, rtc_fire};
    assign sts_clr = (rd_done && paddr == REG_STATUS) ?
                     prdata_q[ST_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= '0;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= '0;
        end else if (wr_en && paddr == REG_MASK) begin
            mask_q <= pwdata[ST_W-1:0];
        end
    end
    assign irq = |(sts_q & mask_q);
    // Wake stays up until software reads the status
    assign rtc_wake = sts_q[ST_RTC_CMP];

    // Read multiplexer
    always_comb begin
        rd_mux = REG_ZERO;
        if (ch_hit) begin
            if (ch_ofs[2:0] == CH_CFG_OFS[2:0]) begin
                rd_mux = {29'h0, ch_armed[ch_idx[2:0]], ch_cfg[ch_idx[2:0]]};
            end else begin
                rd_mux = ch_val[ch_idx[2:0]];
            end
        end else begin
            case (paddr)
                REG_INC: rd_mux = inc_q;
                REG_T8U: rd_mux = t8u;
                REG_T524M: rd_mux = t524m;
                REG_RTC_CMP: rd_mux = rtc_cmp_q;
                REG_RTC_CAP: rd_mux = rtc_cap_q;
                REG_SYST: rd_mux = syst_q[31:0];
                REG_STATUS: rd_mux = {25'h0, sts_q};
                REG_MASK: rd_mux = {25'h0, mask_q};
                default: rd_mux = REG_ZERO;
            endcase
        end
    end

    // Read data is taken in the setup cycle and held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= REG_ZERO;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

endmodule // rtst_timebase

// >>> dv/rtst_timebase_sva.sv
// Port assertions of the time base block
`timescale 1ns/100ps
module rtst_timebase_sva
    import rtst_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic shutdown, // Shutdown level
    input wire logic rtc_wake, // Wake request
    input wire logic irq // Interrupt
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic bad;
    // Past the last channel pair, or off a word boundary
    assign bad = paddr >= 12'h048 || paddr[1:0] != 2'h0;
    sequence acc_s;
        psel && penable;
    endsequence
    sequence rd_setup_s(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    ready_high_a: assert property (acc_s |-> pready)
        else $error("pready low in access");
    err_bad_a: assert property (psel && penable && bad |-> pslverr)
        else $error("no error on bad address");
    err_good_a: assert property (!(psel && penable && bad) |-> !pslverr)
        else $error("error without cause");
    err_data_a: assert property (rd_setup_s(paddr) ##0 bad |=> prdata == 0)
        else $error("data on bad address");
    rdata_hold_a: assert property (acc_s |=> $stable(prdata))
        else $error("read data moved");
    wake_clear_a: assert property ($fell(rtc_wake) |->
        $past(psel && penable && !pwrite && paddr == REG_STATUS))
        else $error("wake fell without status read");
    shut_clear_a: assert property (shutdown && $past(shutdown)
        ##0 rd_setup_s(REG_T8U) |=> prdata == REG_ZERO)
        else $error("view not cleared in shutdown");
    mask_off_a: assert property (psel && penable && pwrite &&
        paddr == REG_MASK && pwdata == 0 |-> ##[1:2] !irq)
        else $error("irq with empty mask");
    wake_seen_c: cover property ($rose(rtc_wake));
endmodule // rtst_timebase_sva

// >>> dv/rtst_lf_partner.sv
// Slow clock source and event consumer facing the time base
`timescale 1ns/100ps
module rtst_lf_partner
    import rtst_pkg::*;
#(
    parameter int HALF = 8 // pclk cycles per half period
)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic run, // Let the slow clock run
    input wire logic [NCH-1:0] ch_event, // Channel events
    output logic low_freq_clock, // Slow clock level
    output int ticks, // Rising edges made
    output int ev_cnt [NCH] // Events seen per channel
);
    int cnt;
    // Rests low between bursts so the bench knows every tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            low_freq_clock <= 1'b0;
            ticks <= 0;
        end else if (run || low_freq_clock) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                low_freq_clock <= !low_freq_clock;
                if (!low_freq_clock) ticks <= ticks + 1;
            end
        end
    end
    // Event consumer counts every pulse per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                ev_cnt[i] <= 0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (ch_event[i]) ev_cnt[i] <= ev_cnt[i] + 1;
            end
        end
    end
endmodule // rtst_lf_partner

// >>> dv/rtst_timebase_tb.sv
// Self-checking bench of the time base block
`timescale 1ns/100ps
module rtst_timebase_tb
    import rtst_pkg::*;
;
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, ca;
    logic [31:0] pwdata = 32'h0, prdata, rdat, st, sl;
    logic pready, pslverr, low_freq_clock, shutdown = 1'b0, rerr, r1;
    logic rtc_cap_trig = 1'b0, rtc_wake, irq, run = 1'b0;
    logic [NCH-1:0] ch_cap_trig = '0, ch_event;
    logic [31:0] inc = 32'hFFFF_FFFF;
    logic [66:0] acc;
    int ticks, ev_cnt [NCH], mismatches = 0, compares = 0, cycles = 0;
    rtst_timebase u_rtst_timebase (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_freq_clock(low_freq_clock),
        .shutdown(shutdown), .rtc_cap_trig(rtc_cap_trig),
        .ch_cap_trig(ch_cap_trig), .ch_event(ch_event),
        .rtc_wake(rtc_wake), .irq(irq));
    rtst_lf_partner #(.HALF(8)) u_rtst_lf_partner (.pclk(pclk),
        .presetn(presetn), .run(run), .ch_event(ch_event),
        .low_freq_clock(low_freq_clock), .ticks(ticks), .ev_cnt(ev_cnt));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic give_verdict();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; returns in the time step of the access edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n == 40) mismatches++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, REG_ZERO);
        chk(rdat, exp);
    endtask
    // Let the slow clock make k ticks, then let it rest
    task automatic spin(input int k);
        int t0;
        t0 = ticks;
        run <= 1'b1;
        for (int i = 0; i < 5000 && ticks < t0 + k; i++) @(posedge pclk);
        run <= 1'b0;
        repeat (30) @(posedge pclk);
        acc = 67'(ticks) * 67'(inc);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(REG_INC, INC_RESET);
        apb(1'b1, REG_T8U, 32'hFFFF_FFFF);
        rd(REG_T8U, REG_ZERO);
        rd(12'h048, REG_ZERO);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, REG_INC, inc);
        rd(REG_INC, inc);
        spin(20);
        rd(REG_T8U, acc[T8U_LSB +: 32]);
        rd(REG_T524M, acc[T524M_LSB +: 32]);
        apb(1'b0, REG_SYST, REG_ZERO);
        chk({31'h0, (rdat - acc[SYST_LSB +: 32]) < 32'h8}, 32'h1);
        @(posedge pclk);
        rtc_cap_trig <= 1'b1;
        @(posedge pclk);
        rtc_cap_trig <= 1'b0;
        rd(REG_RTC_CAP, acc[T8U_LSB +: 32]);
        apb(1'b1, REG_MASK, 32'h0000_0003);
        #20 chk({31'h0, irq}, 32'h1);
        rd(REG_STATUS, 32'h0000_0002);
        #20 chk({31'h0, irq}, 32'h0);
        // Compare 8192 views ahead, about one tick
        apb(1'b1, REG_RTC_CMP, acc[T8U_LSB +: 32] + 32'h0000_2000);
        #20 chk({31'h0, rtc_wake}, 32'h0);
        spin(3);
        chk({31'h0, rtc_wake & irq}, 32'h1);
        apb(1'b1, REG_MASK, REG_ZERO);
        #20 chk({31'h0, irq}, 32'h0);
        rd(REG_STATUS, 32'h0000_0001);
        // Far future does not fire, recent past fires once
        for (int n = 0; n < NCH; n++) begin
            ca = REG_CH_BASE + 12'(n << CH_STRIDE_SH);
            r1 = n[0];
            apb(1'b1, ca + CH_CFG_OFS, {30'h0, 1'b1, r1});
            apb(1'b0, REG_SYST, REG_ZERO);
            sl = r1 ? rdat >> 2 : rdat;
            apb(1'b1, ca + CH_VAL_OFS, sl + 32'h4000_0000);
            rd(ca + CH_CFG_OFS, {29'h0, 2'h3, r1});
            chk(32'(ev_cnt[n]), 32'h0);
            apb(1'b1, ca + CH_VAL_OFS, sl - 32'h10);
            #100 chk(32'(ev_cnt[n]), 32'h1);
            rd(ca + CH_CFG_OFS, {30'h0, 1'b1, r1});
        end
        rd(REG_STATUS, 32'h0000_007C);
        apb(1'b1, ca + CH_CFG_OFS, REG_ZERO);
        apb(1'b0, REG_SYST, REG_ZERO);
        st = rdat;
        ch_cap_trig <= 5'h10;
        @(posedge pclk);
        ch_cap_trig <= 5'h00;
        apb(1'b0, ca + CH_VAL_OFS, REG_ZERO);
        chk({31'h0, (rdat - st) < 32'h8}, 32'h1);
        chk(32'(ev_cnt[4]), 32'h2);
        rd(REG_STATUS, 32'h0000_0040);
        shutdown <= 1'b1;
        rd(REG_T8U, REG_ZERO);
        rd(REG_T524M, REG_ZERO);
        rd(REG_SYST, REG_ZERO);
        shutdown <= 1'b0;
        give_verdict();
    end
endmodule // rtst_timebase_tb
bind rtst_timebase rtst_timebase_sva u_rtst_timebase_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shutdown(shutdown), .rtc_wake(rtc_wake), .irq(irq));
